// File: uflc_defs.vh
// Purpose: constants for the flag clear and receive character block
// Assumes: 32-bit register bus, word aligned byte addresses
// Notes:   definitions only, no logic
`ifndef UFLC_DEFS_VH
`define UFLC_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UFLC_OFS_STATUS      8'h1C
`define UFLC_OFS_FLAG_CLEAR  8'h20
`define UFLC_OFS_RX_CHAR     8'h24
`define UFLC_OFS_IRQ_MASK    8'h30

// ----------------------------------------------------------------
// Flag bit positions in status, clear and mask registers
// ----------------------------------------------------------------
`define UFLC_BIT_CHAR_CMP    17
`define UFLC_BIT_CTS_CHG     9
`define UFLC_BIT_TX_DONE     6
`define UFLC_BIT_LINE_QUIET  4
`define UFLC_BIT_RX_OVF      3
`define UFLC_BIT_NOISE       2
`define UFLC_BIT_FRAMING     1
`define UFLC_BIT_PARITY      0

// ----------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------
`define UFLC_CHAR_W          9
`define UFLC_NUM_FLAGS       8
`define UFLC_RST_FLAGS       8'h00
`define UFLC_RST_MASK        8'h00
`define UFLC_RST_CHAR        9'h000
`define UFLC_RD_ZERO         32'h00000000

// ----------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------
`define UFLC_RESP_OKAY       2'h0
`define UFLC_RESP_SLVERR     2'h2

`endif

// File: uflc_axil.v
// Purpose: AXI4-Lite slave front end for the register file
// Assumes: one write and one read in flight at most
// Notes:   write fires one edge after both address and data are held;
//          read data is captured on the address handshake edge
`timescale 1ns/1ns
`include "uflc_defs.vh"

module uflc_axil (
	// Clock, reset and enable
	input  wire        clock,
	input  wire        rst_b,
	input  wire        ce,
	// Write address and data channels
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// Write response channel
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// Read channels
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Register file side
	output wire        wr_req,
	output reg  [7:0]  wr_addr,
	output reg  [31:0] wr_data,
	output reg  [3:0]  wr_strb,
	input  wire        wr_err,
	output wire        rd_req,
	input  wire [31:0] rd_data,
	input  wire        rd_err
);

	reg aw_full;
	reg w_full;

	// Hold each channel until both are in; no bus ready while frozen
	assign s_axi_awready = ce & ~aw_full;
	assign s_axi_wready  = ce & ~w_full;
	assign s_axi_arready = ce & ~s_axi_rvalid;
	assign wr_req        = ce & aw_full & w_full & ~s_axi_bvalid;
	assign rd_req        = s_axi_arvalid & s_axi_arready;

	// Write side capture and response
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			aw_full      <= 1'b0;
			w_full       <= 1'b0;
			wr_addr      <= 8'h00;
			wr_data      <= 32'h00000000;
			wr_strb      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `UFLC_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full  <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (wr_req) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_err ? `UFLC_RESP_SLVERR
					: `UFLC_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read side: data sampled at the address handshake
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= `UFLC_RD_ZERO;
			s_axi_rresp  <= `UFLC_RESP_OKAY;
		end else if (ce) begin
			if (rd_req) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_err ? `UFLC_RESP_SLVERR
					: `UFLC_RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// File: uflc_top.v
// Purpose: flag clear register and receive character register of the
//          low power serial unit, with status flags and interrupt
// Assumes: event and character inputs are synchronous to clock
// Notes:   the rest of the unit raises one-cycle event pulses here
//
// Summary of operation
// RULE1: A one written to bit 17 of the flag clear register clears match.
// RULE2: A one written to bit 9 clears the clear-to-send change flag.
// RULE3: A one written to bit 6 clears the transmit-done flag.
// RULE4: A one written to bit 4 clears the idle line flag.
// RULE5: A one written to bit 3 clears the receive overflow flag.
// RULE6: A one written to bit 2 clears the start-bit noise flag.
// RULE7: A one written to bit 1 clears the framing error flag.
// RULE8: A one written to bit 0 clears the parity error flag.
// RULE9: The last shifted-in character reads in bits 8:0, read-only.
// RULE10: With parity on, the character MSB holds the received parity.
// RULE11: The receive character register is at 0x24; bits 31:9 read zero.
// RULE12: Zeros and reserved bits written to the flag clear do nothing.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "uflc_defs.vh"

module uflc_top #(
	parameter CHAR_W = `UFLC_CHAR_W
) (
	// Clock, reset and enable
	input  wire              clock,
	input  wire              rst_b,
	input  wire              ce,
	// AXI4-Lite write address and data
	input  wire [7:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0]        s_axi_bresp,
	output wire              s_axi_bvalid,
	input  wire              s_axi_bready,
	// AXI4-Lite read
	input  wire [7:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output wire [31:0]       s_axi_rdata,
	output wire [1:0]        s_axi_rresp,
	output wire              s_axi_rvalid,
	input  wire              s_axi_rready,
	// Flag events from the rest of the serial unit
	input  wire              evt_char_match,
	input  wire              evt_cts_change,
	input  wire              evt_tx_done,
	input  wire              evt_line_quiet,
	input  wire              evt_rx_overflow,
	input  wire              evt_noise,
	input  wire              evt_framing_err,
	input  wire              evt_parity_err,
	// Received character from the input shift register
	input  wire [CHAR_W-1:0] rx_shift_char,
	input  wire              rx_char_load,
	// Flag levels back to the unit, and interrupt
	output wire [31:0]       status_flags,
	output wire              irq
);

	// ------------------------------------------------------------
	// Flag layout helpers
	// ------------------------------------------------------------

	// Packed flag vector to register layout
	function [31:0] uflc_expand;
		input [7:0] f;
		begin
			uflc_expand                        = 32'h00000000;
			uflc_expand[`UFLC_BIT_CHAR_CMP]    = f[7];
			uflc_expand[`UFLC_BIT_CTS_CHG]     = f[6];
			uflc_expand[`UFLC_BIT_TX_DONE]     = f[5];
			uflc_expand[`UFLC_BIT_LINE_QUIET]  = f[4];
			uflc_expand[`UFLC_BIT_RX_OVF]      = f[3];
			uflc_expand[`UFLC_BIT_NOISE]       = f[2];
			uflc_expand[`UFLC_BIT_FRAMING]     = f[1];
			uflc_expand[`UFLC_BIT_PARITY]      = f[0];
		end
	endfunction

	// Register layout to packed vector; reserved bits are dropped
	function [7:0] uflc_pack;
		input [31:0] r;
		begin
			uflc_pack = {r[`UFLC_BIT_CHAR_CMP], r[`UFLC_BIT_CTS_CHG],
				r[`UFLC_BIT_TX_DONE], r[`UFLC_BIT_LINE_QUIET],
				r[`UFLC_BIT_RX_OVF], r[`UFLC_BIT_NOISE],
				r[`UFLC_BIT_FRAMING], r[`UFLC_BIT_PARITY]};
		end
	endfunction

	// Byte strobes widened to a bit mask
	function [31:0] uflc_lanes;
		input [3:0] s;
		begin
			uflc_lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		end
	endfunction

	// ------------------------------------------------------------
	// State and bus wires
	// ------------------------------------------------------------
	reg  [7:0]        flags;
	reg  [7:0]        irq_mask;
	reg  [CHAR_W-1:0] rx_char;
	reg  [31:0]       rd_data;
	reg               rd_err;
	reg               wr_err;
	wire              wr_req;
	wire [7:0]        wr_addr;
	wire [31:0]       wr_data;
	wire [3:0]        wr_strb;
	wire              rd_req;
	wire [31:0]       wr_bits;
	wire              clr_hit;
	wire              mask_hit;
	wire [7:0]        clr_vec;
	wire [7:0]        evt_vec;
	wire [7:0]        next_flags;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	uflc_axil i_uflc_axil (
		.clock         (clock),
		.rst_b         (rst_b),
		.ce            (ce),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_req        (wr_req),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_err        (wr_err),
		.rd_req        (rd_req),
		.rd_data       (rd_data),
		.rd_err        (rd_err)
	);

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------

	// Only bits in enabled byte lanes take part in a write
	assign wr_bits  = wr_data & uflc_lanes(wr_strb);
	assign clr_hit  = wr_req & (wr_addr == `UFLC_OFS_FLAG_CLEAR);
	assign mask_hit = wr_req & (wr_addr == `UFLC_OFS_IRQ_MASK);

	// Ones clear, zeros and reserved positions fall out of the pack
	assign clr_vec = clr_hit ? uflc_pack(wr_bits) : 8'h00; // RULE12

	// Writes to read-only or unmapped words answer with an error
	always @* begin
		case (wr_addr)
			`UFLC_OFS_FLAG_CLEAR: wr_err = 1'b0;
			`UFLC_OFS_IRQ_MASK:   wr_err = 1'b0;
			default:              wr_err = 1'b1;
		endcase
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	assign evt_vec = {evt_char_match, evt_cts_change, evt_tx_done,
		evt_line_quiet, evt_rx_overflow, evt_noise,
		evt_framing_err, evt_parity_err};

	// An event in the clearing cycle survives, so none is lost
	assign next_flags = (flags & ~clr_vec) | evt_vec;

	// Sticky flags, each cleared by a one in its clear position
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			flags <= `UFLC_RST_FLAGS;
		end else if (ce) begin
			flags[7] <= next_flags[7]; // RULE1
			flags[6] <= next_flags[6]; // RULE2
			flags[5] <= next_flags[5]; // RULE3
			flags[4] <= next_flags[4]; // RULE4
			flags[3] <= next_flags[3]; // RULE5
			flags[2] <= next_flags[2]; // RULE6
			flags[1] <= next_flags[1]; // RULE7
			flags[0] <= next_flags[0]; // RULE8
		end
	end

	// ------------------------------------------------------------
	// Interrupt mask and output
	// ------------------------------------------------------------

	// Mask uses the same layout as the status word
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			irq_mask <= `UFLC_RST_MASK;
		end else if (ce && mask_hit) begin
			// Written lanes take the new bits, lanes left off keep theirs
			irq_mask <= uflc_pack(wr_bits) |
				(irq_mask & uflc_pack(uflc_lanes(~wr_strb)));
		end
	end

	// Level output, drops as soon as the last enabled flag clears
	assign irq          = |(flags & irq_mask);
	assign status_flags = uflc_expand(flags);

	// ------------------------------------------------------------
	// Receive character holding register
	// ------------------------------------------------------------

	// Taken whole from the shift register; the MSB stays as received
	// so with parity on it carries the parity bit, not data.
	// Reset gives a defined zero although software must not rely on it.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_char <= `UFLC_RST_CHAR;
		end else if (ce && rx_char_load) begin
			rx_char <= rx_shift_char; // RULE9 RULE10
		end
	end

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------

	// Reads have no side effect; the clear register reads as zero
	always @* begin
		rd_data = `UFLC_RD_ZERO;
		rd_err  = 1'b0;
		case (s_axi_araddr)
			`UFLC_OFS_STATUS: begin
				rd_data = uflc_expand(flags);
			end
			`UFLC_OFS_FLAG_CLEAR: begin
				rd_data = `UFLC_RD_ZERO;
			end
			`UFLC_OFS_RX_CHAR: begin
				rd_data[CHAR_W-1:0] = rx_char; // RULE9 RULE11
			end
			`UFLC_OFS_IRQ_MASK: begin
				rd_data = uflc_expand(irq_mask);
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

endmodule

// File: uflc_monitor.sv
// Purpose: port checker for the flag clear and rx char block
// Assumes: flags only fall at a completed clear write
// Notes:   bound to every instance of the top module
`timescale 1ns/1ns
`include "uflc_defs.vh"

module uflc_monitor (
	// Clock and reset
	input wire        clock,
	input wire        rst_b,
	// Write response
	input wire        s_axi_bvalid,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bready,
	// Read channels
	input wire [7:0]  s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	// Flags and interrupt
	input wire [31:0] status_flags,
	input wire        irq
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Read steps: address taken, then an OKAY answer
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_ok;
		s_axi_rvalid && s_axi_rresp == `UFLC_RESP_OKAY;
	endsequence

	// A flag drops only at the edge that raises an OKAY response
	AST_FCLR: assert property (
		|($past(status_flags) & ~status_flags) |->
		$rose(s_axi_bvalid) && s_axi_bresp == `UFLC_RESP_OKAY)
		else $error("flag cleared without a write");
	AST_RESV: assert property (
		(status_flags & ~32'h0002025F) == 32'h0)
		else $error("reserved status bit set");
	AST_IRQ_IDLE: assert property (status_flags == 32'h0 |-> !irq)
		else $error("interrupt with no flag");
	AST_RD_ANS: assert property (s_ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RX_RESV: assert property (
		s_ar_take ##0 s_axi_araddr == `UFLC_OFS_RX_CHAR |=>
		s_rd_ok ##0 s_axi_rdata[31:9] == 23'h0)
		else $error("rx char upper bits not zero");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer not held");
	AST_AR_ONE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read taken");
endmodule

bind uflc_top uflc_monitor i_uflc_monitor (.clock(clock), .rst_b(rst_b),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.status_flags(status_flags), .irq(irq));

// File: uflc_rx_src.sv
// Purpose: far side model handing received characters in
// Assumes: one character per request, even parity in the MSB
// Notes:   the character lines churn between loads on purpose
`timescale 1ns/1ns

module uflc_rx_src (
	// Clock and reset
	input  wire       clock,
	input  wire       rst_b,
	// Request from the bench
	input  wire       go,
	input  wire [8:0] go_char,
	input  wire       par_on,
	input  wire [3:0] go_dly,
	// Toward the receive register, and busy back to the bench
	output reg  [8:0] rx_shift_char,
	output reg        rx_char_load,
	output reg        busy
);
	reg [3:0] cnt;
	reg [8:0] hold;

	// Delay, then a one-cycle load; stale data is never left standing
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			{busy, cnt, hold, rx_char_load, rx_shift_char} <= 24'h000000;
		end else begin
			rx_char_load <= 1'b0;
			rx_shift_char <= ~rx_shift_char;
			if (go) begin
				busy <= 1'b1;
				cnt <= go_dly;
				hold <= par_on ? {^go_char[7:0], go_char[7:0]} : go_char;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
				rx_char_load <= 1'b1;
				rx_shift_char <= hold;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule

// File: uart_flag_clear_rx_data_bench.sv
// Purpose: self-checking bench for the flag clear and rx char block
// Assumes: one read and one write in flight, events pulsed by the bench
// Notes:   the model keeps flags, mask and last character
`timescale 1ns/1ns
`include "uflc_defs.vh"
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
	end end

module uart_flag_clear_rx_data_bench;
	// ------------------------------------------------------------
	// Signals, model and instances
	// ------------------------------------------------------------
	localparam [31:0] VALID = 32'h0002025F;
	reg         clock = 1'b0;
	reg         rst_b = 1'b0;
	reg         ce = 1'b1;
	reg  [7:0]  awaddr = 8'h00;
	reg  [7:0]  araddr = 8'h00;
	reg  [31:0] wdata = 32'h0;
	reg  [3:0]  wstrb = 4'h0;
	reg         awvalid = 1'b0;
	reg         wvalid = 1'b0;
	reg         bready = 1'b0;
	reg         arvalid = 1'b0;
	reg         rready = 1'b0;
	reg  [7:0]  ev = 8'h00;
	reg         go = 1'b0;
	reg         par_on = 1'b0;
	reg  [8:0]  go_char = 9'h000;
	reg  [3:0]  go_dly = 4'h0;
	wire        awready, wready, bvalid, arready, rvalid, irq, rx_load, busy;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata, sf;
	wire [8:0]  rx_char;
	integer     err_count = 0;
	integer     tests_run = 0;
	integer     k, seed;
	reg  [31:0] ef = 32'h0;
	reg  [31:0] em = 32'h0;
	reg  [8:0]  ec = 9'h000;
	reg  [31:0] lm, d, rd_v;
	reg  [8:0]  ch;
	reg  [1:0]  r, er;
	int         pos [8] = '{0, 1, 2, 3, 4, 6, 9, 17};

	uflc_top i_uflc_top (.clock(clock), .rst_b(rst_b), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.evt_char_match(ev[7]), .evt_cts_change(ev[6]), .evt_tx_done(ev[5]),
		.evt_line_quiet(ev[4]), .evt_rx_overflow(ev[3]), .evt_noise(ev[2]),
		.evt_framing_err(ev[1]), .evt_parity_err(ev[0]),
		.rx_shift_char(rx_char), .rx_char_load(rx_load),
		.status_flags(sf), .irq(irq));
	uflc_rx_src i_uflc_rx_src (.clock(clock), .rst_b(rst_b), .go(go),
		.go_char(go_char), .par_on(par_on), .go_dly(go_dly),
		.rx_shift_char(rx_char), .rx_char_load(rx_load), .busy(busy));

	// Free-running clock
	initial begin
		forever #4 clock = ~clock;
	end

	// Event vector to status layout
	function [31:0] to_map(input [7:0] v);
		integer i;
		begin
			to_map = 32'h0;
			for (i = 0; i < 8; i++) if (v[i]) to_map[pos[i]] = 1'b1;
		end
	endfunction

	// Pulse events for one enabled edge
	task pulse(input [7:0] v);
		begin
			@(posedge clock);
			ev <= v;
			@(posedge clock);
			ev <= 8'h00;
			if (ce) ef = ef | to_map(v);
			@(negedge clock);
		end
	endtask

	// Bus write; bready may trail bvalid so a held answer is seen too
	task wr(input [7:0] a, input [31:0] dd, input [3:0] s);
		reg ta, tw, tb, sn;
		integer n;
		begin
			@(posedge clock);
			{awaddr, wdata, wstrb} <= {a, dd, s};
			{awvalid, wvalid, bready} <= {2'b11, 1'($urandom)};
			tb = 1'b0;
			n = 0;
			while (!tb && n < 40) begin
				@(negedge clock);
				{ta, tw} = {awvalid & awready, wvalid & wready};
				{tb, sn, r} = {bvalid & bready, bvalid, bresp};
				n++;
				@(posedge clock);
				if (ta) awvalid <= 1'b0;
				if (tw) wvalid <= 1'b0;
				if (sn && !tb) bready <= 1'b1;
			end
			bready <= 1'b0;
			lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
			er = (a == 8'h20 || a == 8'h30) ? 2'h0 : 2'h2;
			if (a == 8'h20) ef = ef & ~(dd & lm);
			if (a == 8'h30) em = (em & ~lm) | (dd & lm & VALID);
			`CHK(r, er)
		end
	endtask

	// Bus read compared with the model
	task check_rd(input [7:0] a);
		reg tt, tr, sn;
		integer n;
		begin
			@(posedge clock);
			{araddr, arvalid, rready} <= {a, 1'b1, 1'($urandom)};
			tr = 1'b0;
			n = 0;
			while (!tr && n < 40) begin
				@(negedge clock);
				{tt, tr, sn} = {arvalid & arready, rvalid & rready, rvalid};
				rd_v = rdata;
				r = rresp;
				n++;
				@(posedge clock);
				if (tt) arvalid <= 1'b0;
				if (sn && !tr) rready <= 1'b1;
			end
			rready <= 1'b0;
			d = (a == 8'h1C) ? ef : (a == 8'h30) ? em : 32'h0;
			if (a == 8'h24) d = {23'h0, ec};
			er = (a == 8'h1C || a == 8'h20 || a == 8'h24 || a == 8'h30) ?
				2'h0 : 2'h2;
			`CHK(rd_v, d)
			`CHK(r, er)
		end
	endtask

	// Hand one character in through the far side model
	task send(input [8:0] c, input p, input [3:0] dl);
		integer n;
		begin
			@(posedge clock);
			go <= 1'b1;
			go_char <= c;
			par_on <= p;
			go_dly <= dl;
			@(posedge clock);
			go <= 1'b0;
			n = 0;
			@(negedge clock);
			while (busy && n < 40) begin
				@(negedge clock);
				n++;
			end
		end
	endtask

	task give_verdict;
		begin
			$display("checks %0d, mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#400000;
		err_count++;
		give_verdict;
	end

	// Main sequence
	initial begin
		seed = $urandom(32'h72e0);
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		// Reset values and unmapped words
		for (k = 0; k < 7; k++) check_rd(8'(8'h1C + 4 * k));
		// Each clear bit alone, random reserved bits beside it
		for (k = 0; k < 8; k++) begin
			pulse(8'hFF);
			d = $urandom & ~VALID;
			wr(`UFLC_OFS_FLAG_CLEAR, d | (32'h1 << pos[k]), 4'hF);
			`CHK(sf, ef)
			check_rd(`UFLC_OFS_STATUS);
		end
		// Random data and lanes; zeros leave flags alone
		for (k = 0; k < 6; k++) begin
			pulse(8'hFF);
			wr(`UFLC_OFS_FLAG_CLEAR, $urandom, 4'($urandom));
			`CHK(sf, ef)
		end
		// Read-only words refuse writes
		wr(`UFLC_OFS_RX_CHAR, 32'hFFFFFFFF, 4'hF);
		wr(`UFLC_OFS_STATUS, 32'hFFFFFFFF, 4'hF);
		`CHK(sf, ef)
		// Interrupt raised, masked and cleared
		for (k = 0; k < 6; k++) begin
			wr(`UFLC_OFS_IRQ_MASK, $urandom, 4'hF);
			pulse(8'($urandom));
			`CHK(irq, |(ef & em))
			wr(`UFLC_OFS_FLAG_CLEAR, 32'hFFFFFFFF, 4'hF);
			`CHK(irq, 1'b0)
		end
		check_rd(`UFLC_OFS_IRQ_MASK);
		// Events are ignored while frozen
		ce <= 1'b0;
		pulse(8'hFF);
		`CHK(sf, ef)
		@(posedge clock);
		ce <= 1'b1;
		// Characters with and without parity, prompt and slow
		for (k = 0; k < 8; k++) begin
			ch = 9'($urandom);
			send(ch, k[0], 4'(k));
			ec = k[0] ? {^ch[7:0], ch[7:0]} : ch;
			check_rd(`UFLC_OFS_RX_CHAR);
		end
		// Back-to-back loads: the last one is read
		send(9'h1A5, 1'b0, 4'h0);
		send(9'h05A, 1'b0, 4'h0);
		ec = 9'h05A;
		check_rd(`UFLC_OFS_RX_CHAR);
		give_verdict;
	end
endmodule
